/* File: design/scbm_map.vh */
`ifndef SCBM_MAP_VH
`define SCBM_MAP_VH
// Operation select codes presented on opSel.
`define SCBM_OP_NOP        4'h0
`define SCBM_OP_TRAP       4'h1
`define SCBM_OP_RTE        4'h2
`define SCBM_OP_SLEEP      4'h3
`define SCBM_OP_LDC_INC    4'h4
`define SCBM_OP_STC_DEC    4'h5
`define SCBM_OP_FLAGS_AND_IMM_OP       4'h6
`define SCBM_OP_ORC        4'h7
`define SCBM_OP_FLAGS_XOR_IMM_OP       4'h8
`define SCBM_OP_MOVE_B     4'h9
`define SCBM_OP_MOVE_W     4'hA
// Flag register layout: interrupt mask bit.
`define SCBM_CCR_IMASK     7
`define SCBM_CCR_RESET     8'h80
// State counts.
`define SCBM_ST_TRAP_NORM  5'h0E
`define SCBM_ST_TRAP_ADV   5'h10
`define SCBM_ST_SHORT      5'h02
`define SCBM_ST_LDST       5'h08
`define SCBM_ST_RTE        5'h0A
`define SCBM_ST_MOVE_BASE  5'h08
`define SCBM_ST_MOVE_PER   5'h04
`endif

/* File: design/scbm_exec.v */
`timescale 1ns/10ps
`include "scbm_map.vh"
module scbm_exec #(
    parameter PTR_W = 32 // Pointer width.
) (
    input  wire             sys_clk,      // System clock.
    input  wire             sys_rst,      // Synchronous reset.
    input  wire             opStart,      // Start pulse.
    input  wire [3:0]       opSel,        // Operation code.
    input  wire [7:0]       opImm,        // Immediate or trap vector.
    input  wire             advMode,      // Advanced mode timing.
    input  wire [PTR_W-1:0] pcIn,         // Current PC.
    input  wire [PTR_W-1:0] spIn,         // Current stack pointer.
    input  wire [PTR_W-1:0] ptrIn,        // Pointer register.
    input  wire [PTR_W-1:0] srcIn,        // Move source pointer.
    input  wire [PTR_W-1:0] dstIn,        // Move destination pointer.
    input  wire [15:0]      cntIn,        // Move count.
    input  wire [15:0]      memRdata,     // Read data.
    output reg              busy,         // Operation in progress.
    output reg              done,         // Completion pulse.
    output reg              sleepQ,       // Powerdown state.
    output reg  [7:0]       ccrQ,         // Flag register.
    output reg  [PTR_W-1:0] pcQ,          // PC result.
    output reg  [PTR_W-1:0] spQ,          // Stack pointer result.
    output reg  [PTR_W-1:0] ptrQ,         // Pointer result.
    output reg  [PTR_W-1:0] srcQ,         // Source pointer result.
    output reg  [PTR_W-1:0] dstQ,         // Destination pointer result.
    output reg  [15:0]      cntQ,         // Count result.
    output reg              memRd,        // Read strobe.
    output reg              memWr,        // Write strobe.
    output reg              memByte,      // Byte access.
    output reg  [PTR_W-1:0] memAddr,      // Access address.
    output reg  [15:0]      memWdata      // Write data.
);
    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    localparam S_IDLE = 2'h0;
    localparam S_RUN  = 2'h1;
    localparam S_MOVE = 2'h2;

    // ----------------------------------------------------------------
    // Pointer steps
    // ----------------------------------------------------------------
    // Sized to the pointer so that another PTR_W never leaves a silent
    // width change in the address arithmetic.
    localparam [PTR_W-1:0] PTR_ONE = {{(PTR_W-2){1'b0}}, 2'h1};
    localparam [PTR_W-1:0] PTR_TWO = {{(PTR_W-2){1'b0}}, 2'h2};

    reg [1:0]  state;
    reg [3:0]  op;
    reg [4:0]  step;
    reg [4:0]  waitCnt;
    reg [1:0]  mvPh;
    reg        wordCnt;

    // ----------------------------------------------------------------
    // Operation length
    // ----------------------------------------------------------------
    // State count of an operation, base part only for moves; the caller takes off the start cycle.
    function [4:0] stateCount;
        input [3:0] o;
        input       adv;
        begin
            case (o)
                `SCBM_OP_TRAP:    stateCount = adv ? `SCBM_ST_TRAP_ADV
                                                   : `SCBM_ST_TRAP_NORM;
                `SCBM_OP_RTE:     stateCount = `SCBM_ST_RTE;
                `SCBM_OP_LDC_INC,
                `SCBM_OP_STC_DEC: stateCount = `SCBM_ST_LDST;
                `SCBM_OP_MOVE_B,
                `SCBM_OP_MOVE_W:  stateCount = `SCBM_ST_MOVE_BASE;
                default:          stateCount = `SCBM_ST_SHORT;
            endcase
        end
    endfunction

    wire [15:0] cntNext = cntQ - 16'h0001;
    wire        cntZero = wordCnt ? (cntQ == 16'h0000)
                                  : (cntQ[7:0] == 8'h00);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= S_IDLE; op <= 4'h0; step <= 5'h00; waitCnt <= 5'h00;
            mvPh <= 2'h0; wordCnt <= 1'b0;
            busy <= 1'b0; done <= 1'b0; sleepQ <= 1'b0;
            ccrQ <= `SCBM_CCR_RESET; pcQ <= {PTR_W{1'b0}};
            spQ <= {PTR_W{1'b0}}; ptrQ <= {PTR_W{1'b0}};
            srcQ <= {PTR_W{1'b0}}; dstQ <= {PTR_W{1'b0}};
            cntQ <= 16'h0000; memRd <= 1'b0; memWr <= 1'b0;
            memByte <= 1'b0; memAddr <= {PTR_W{1'b0}};
            memWdata <= 16'h0000;
        end else begin
            done <= 1'b0;
            memRd <= 1'b0;
            memWr <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (opStart) begin
                        op <= opSel; busy <= 1'b1; step <= 5'h00;
                        waitCnt <= stateCount(opSel, advMode) - 5'h01;
                        pcQ <= pcIn; spQ <= spIn; ptrQ <= ptrIn;
                        srcQ <= srcIn; dstQ <= dstIn; cntQ <= cntIn;
                        wordCnt <= (opSel == `SCBM_OP_MOVE_W);
                        sleepQ <= 1'b0;
                        state <= S_RUN;
                    end
                end
                S_RUN: begin
                    step <= step + 5'h01;
                    waitCnt <= waitCnt - 5'h01;
                    case (op)
                        `SCBM_OP_TRAP: begin
                            // The PC goes on the stack first, so the flags
                            // word ends up on top for the return to pop.
                            if (step == 5'h00) begin
                                memWr <= 1'b1; memByte <= 1'b0;
                                memAddr <= spQ - PTR_TWO;
                                memWdata <= pcQ[15:0];
                                spQ <= spQ - PTR_TWO;
                            end else if (step == 5'h01) begin
                                memWr <= 1'b1;
                                memAddr <= spQ - PTR_TWO;
                                memWdata <= {ccrQ, ccrQ};
                                spQ <= spQ - PTR_TWO;
                                ccrQ[`SCBM_CCR_IMASK] <= 1'b1;
                                pcQ <= {{(PTR_W-8){1'b0}}, opImm};
                            end
                        end
                        `SCBM_OP_RTE: begin
                            // Read data returns the cycle after the strobe.
                            if (step == 5'h00) begin
                                memRd <= 1'b1; memByte <= 1'b0;
                                memAddr <= spQ; spQ <= spQ + PTR_TWO;
                            end else if (step == 5'h01) begin
                                memRd <= 1'b1;
                                memAddr <= spQ; spQ <= spQ + PTR_TWO;
                            end else if (step == 5'h02) begin
                                ccrQ <= memRdata[15:8];
                            end else if (step == 5'h03) begin
                                pcQ <= {{(PTR_W-16){1'b0}}, memRdata};
                            end
                        end
                        `SCBM_OP_SLEEP:
                            if (step == 5'h00) sleepQ <= 1'b1;
                        `SCBM_OP_LDC_INC: begin
                            if (step == 5'h00) begin
                                memRd <= 1'b1; memByte <= 1'b0;
                                memAddr <= ptrQ; ptrQ <= ptrQ + PTR_TWO;
                            end else if (step == 5'h02) begin
                                // Data for the step-0 read is on the bus
                                // only in the cycle after the strobe.
                                ccrQ <= memRdata[15:8];
                            end
                        end
                        `SCBM_OP_STC_DEC:
                            if (step == 5'h00) begin
                                ptrQ <= ptrQ - PTR_TWO;
                                memWr <= 1'b1; memByte <= 1'b0;
                                memAddr <= ptrQ - PTR_TWO;
                                memWdata <= {ccrQ, ccrQ};
                            end
                        `SCBM_OP_FLAGS_AND_IMM_OP:
                            if (step == 5'h00) ccrQ <= ccrQ & opImm;
                        `SCBM_OP_ORC:
                            if (step == 5'h00) ccrQ <= ccrQ | opImm;
                        `SCBM_OP_FLAGS_XOR_IMM_OP:
                            if (step == 5'h00) ccrQ <= ccrQ ^ opImm;
                        `SCBM_OP_MOVE_B, `SCBM_OP_MOVE_W: ;
                        default:
                            if (step == 5'h00) pcQ <= pcQ + PTR_TWO;
                    endcase
                    if (waitCnt == 5'h00) begin
                        if ((op == `SCBM_OP_MOVE_B || op == `SCBM_OP_MOVE_W)
                            && !cntZero) begin
                            state <= S_MOVE; mvPh <= 2'h0;
                        end else begin
                            state <= S_IDLE; busy <= 1'b0; done <= 1'b1;
                        end
                    end
                end
                S_MOVE: begin
                    // Four cycles per byte: read, wait for the data,
                    // write it out, then step the pointers and count.
                    mvPh <= mvPh + 2'h1;
                    case (mvPh)
                        2'h0: begin
                            memRd <= 1'b1; memByte <= 1'b1;
                            memAddr <= srcQ;
                        end
                        2'h1: begin
                            // Read data is not on the bus until next cycle.
                        end
                        2'h2: begin
                            memWr <= 1'b1; memAddr <= dstQ;
                            memWdata <= {8'h00, memRdata[7:0]};
                        end
                        default: begin
                            srcQ <= srcQ + PTR_ONE;
                            dstQ <= dstQ + PTR_ONE;
                            if (wordCnt) cntQ <= cntNext;
                            else cntQ <= {cntQ[15:8], cntNext[7:0]};
                            if ((wordCnt ? cntNext : {8'h00, cntNext[7:0]})
                                == 16'h0000) begin
                                state <= S_IDLE; busy <= 1'b0;
                                done <= 1'b1;
                            end
                        end
                    endcase
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

/* File: tb/scbm_exec_properties.sv */
`timescale 1ns/10ps
`include "scbm_map.vh"
// ----
// Executor port checks
// ----
module scbm_exec_chk #(
    parameter PTR_W = 32 // Width.
) (
    input wire             sys_clk, // Clock.
    input wire             sys_rst, // Reset.
    input wire             opStart, // Start.
    input wire [3:0]       opSel,   // Code.
    input wire [7:0]       opImm,   // Imm.
    input wire             advMode, // Mode.
    input wire [PTR_W-1:0] ptrIn,   // Ptr.
    input wire             busy,    // Busy.
    input wire             done,    // Done.
    input wire             sleepQ,  // Sleep.
    input wire [7:0]       ccrQ,    // Flags.
    input wire [PTR_W-1:0] ptrQ     // Ptr out.
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // A start is only taken while idle, so every check keys on this.
    wire go = opStart && !busy;
    // The done register is set on the edge N states after the start and
    // is seen by the properties one edge later, hence N plus one.
    short_done_a:
    assert property (go && opSel inside {`SCBM_OP_NOP, `SCBM_OP_SLEEP,
        [`SCBM_OP_FLAGS_AND_IMM_OP:`SCBM_OP_FLAGS_XOR_IMM_OP]} |-> ##3 done) else $error("short");
    ldst_done_a:
    assert property (go && opSel inside {`SCBM_OP_LDC_INC, `SCBM_OP_STC_DEC}
        |-> ##9 done) else $error("ldst");
    trap_norm_a:
    assert property (go && opSel == `SCBM_OP_TRAP && !advMode |-> ##15
        done && ccrQ[`SCBM_CCR_IMASK]) else $error("trap norm");
    trap_adv_a:
    assert property (go && opSel == `SCBM_OP_TRAP && advMode |-> ##17
        done && ccrQ[`SCBM_CCR_IMASK]) else $error("trap adv");
    rte_done_a:
    assert property (go && opSel == `SCBM_OP_RTE |-> ##11 done)
        else $error("rte");
    sleep_keep_a:
    assert property (go && opSel == `SCBM_OP_SLEEP |-> ##3
        sleepQ && ccrQ == $past(ccrQ, 3)) else $error("sleep");
    xor_imm_a:
    assert property (go && opSel == `SCBM_OP_FLAGS_XOR_IMM_OP |-> ##3
        ccrQ == ($past(ccrQ, 3) ^ $past(opImm, 3))) else $error("xor");
    ldc_ptr_a:
    assert property (go && opSel == `SCBM_OP_LDC_INC |-> ##9
        ptrQ == $past(ptrIn, 9) + PTR_W'(2)) else $error("ldc ptr");
    move_w_c: cover property (go && opSel == `SCBM_OP_MOVE_W);
    trap_c: cover property (go && opSel == `SCBM_OP_TRAP && advMode);
    rte_c: cover property (go && opSel == `SCBM_OP_RTE);
endmodule
bind scbm_exec scbm_exec_chk #(.PTR_W(PTR_W)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .opStart(opStart),
    .opSel(opSel), .opImm(opImm), .advMode(advMode), .ptrIn(ptrIn),
    .busy(busy), .done(done), .sleepQ(sleepQ), .ccrQ(ccrQ), .ptrQ(ptrQ));

/* File: tb/scbm_mem.sv */
`timescale 1ns/10ps
module scbm_mem (
    input  wire        sys_clk,  // Clock.
    input  wire        memRd,    // Read.
    input  wire        memWr,    // Write.
    input  wire        memByte,  // Byte.
    input  wire [31:0] memAddr,  // Address.
    input  wire [15:0] memWdata, // Data in.
    output reg  [15:0] memRdata  // Data out.
);
    reg  [7:0] mem [0:255];
    wire [7:0] a = memAddr[7:0];
    initial memRdata = 16'h0000;
    // Idle data is inverted so a late sample never matches by luck.
    always @(posedge sys_clk) begin
        memRdata <= memRd ? {mem[a], memByte ? mem[a] : mem[a + 8'h1]}
                          : ~memRdata;
        if (memWr)
            mem[a] <= memByte ? memWdata[7:0] : memWdata[15:8];
        if (memWr && !memByte)
            mem[a + 8'h1] <= memWdata[7:0];
    end
endmodule

/* File: tb/system_control_and_block_move_exec_tb.sv */
`timescale 1ns/10ps
`include "scbm_map.vh"
module system_control_and_block_move_exec_tb;
    reg         sys_clk = 1'b0, sys_rst = 1'b1, opStart = 1'b0;
    reg         advMode = 1'b0;
    reg  [3:0]  opSel = 4'h0;
    reg  [7:0]  opImm = 8'h00, expCcr = 8'h80, lfsr = 8'h4C, keep;
    reg  [15:0] cntIn = 16'h0000;
    reg  [31:0] pcIn = 32'h0, spIn = 32'h0, ptrIn = 32'h0, cyc = 32'h0;
    reg  [31:0] srcIn = 32'h40, dstIn = 32'h80;
    reg  [73:0] n;
    reg  [73:0] notes [$];
    wire [15:0] memRdata, memWdata, cntQ;
    wire [31:0] pcQ, spQ, ptrQ, srcQ, dstQ, memAddr;
    wire [7:0]  ccrQ;
    wire        busy, done, sleepQ, memRd, memWr, memByte;
    integer     errors = 0, checks_done = 0, k, i, j;
    scbm_exec u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .opStart(opStart),
        .opSel(opSel), .opImm(opImm), .advMode(advMode), .pcIn(pcIn),
        .spIn(spIn), .ptrIn(ptrIn), .srcIn(srcIn), .dstIn(dstIn),
        .cntIn(cntIn), .memRdata(memRdata), .busy(busy), .done(done),
        .sleepQ(sleepQ), .ccrQ(ccrQ), .pcQ(pcQ), .spQ(spQ), .ptrQ(ptrQ),
        .srcQ(srcQ), .dstQ(dstQ), .cntQ(cntQ), .memRd(memRd), .memWr(memWr),
        .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata));
    scbm_mem u_mem (.sys_clk(sys_clk), .memRd(memRd), .memWr(memWr),
        .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
        .memRdata(memRdata));
    function [7:0] nxt(input [7:0] v);
        nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task cmp(input [47:0] nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("[ERR] %0s exp %0h got %0h", nm, e, g);
            end
        end
    endtask
    // The note holds flags, done cycle, result select and result.
    // The start is taken one edge after the push and done is seen one
    // edge after it is set, so the count is offset by two.
    task run(input [3:0] op, input [31:0] len, input [1:0] s,
             input [31:0] aux);
        begin
            @(posedge sys_clk);
            opSel <= op;
            opStart <= 1'b1;
            notes.push_back({expCcr, cyc + 32'h2 + len, s, aux});
            @(posedge sys_clk);
            opStart <= 1'b0;
            for (i = 0; i < 2000 && done !== 1'b1; i = i + 1)
                @(posedge sys_clk);
            if (done !== 1'b1)
                errors = errors + 1;
            $display("test op %0h ended", op);
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 32'h1;
        if (done === 1'b1) begin
            n = notes.pop_front();
            cmp("flags", {24'h0, n[73:66]}, {24'h0, ccrQ});
            cmp("cycles", n[65:34], cyc);
            if (n[33:32] != 2'h0)
                cmp("result", n[31:0], n[33:32] == 2'h1 ? pcQ
                    : n[33:32] == 2'h2 ? ptrQ : dstQ);
        end
    end
    initial forever #10 sys_clk = ~sys_clk;
    initial begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        pcIn <= 32'h100;
        run(`SCBM_OP_NOP, 2, 2'h1, 32'h102);
        for (k = 0; k < 7; k = k + 1) begin
            lfsr = nxt(lfsr);
            j = k % 3;
            keep = k == 6 ? lfsr & 8'h7F : lfsr;
            opImm <= keep;
            expCcr = j == 0 ? expCcr & keep
                   : j == 1 ? expCcr | keep : expCcr ^ keep;
            run(4'(`SCBM_OP_FLAGS_AND_IMM_OP + j), 2, 2'h0, 32'h0);
        end
        ptrIn <= 32'h20;
        keep = expCcr;
        run(`SCBM_OP_STC_DEC, 8, 2'h2, 32'h1E);
        opImm <= 8'hFF;
        expCcr = ~expCcr;
        run(`SCBM_OP_FLAGS_XOR_IMM_OP, 2, 2'h0, 32'h0);
        ptrIn <= 32'h1E;
        expCcr = keep;
        run(`SCBM_OP_LDC_INC, 8, 2'h2, 32'h20);
        for (k = 0; k < 2; k = k + 1) begin
            pcIn <= 32'h1234;
            spIn <= 32'hF0;
            opImm <= 8'h03;
            advMode <= k[0];
            keep = expCcr;
            expCcr = expCcr | 8'h80;
            run(`SCBM_OP_TRAP, 14 + 2 * k, 2'h1, 32'h3);
            spIn <= 32'hEC;
            expCcr = keep;
            run(`SCBM_OP_RTE, 10, 2'h1, 32'h1234);
        end
        run(`SCBM_OP_SLEEP, 2, 2'h0, 32'h0);
        for (k = 0; k < 4; k = k + 1)
            u_mem.mem[8'h40 + k] = nxt(lfsr + 8'(k));
        for (k = 0; k < 4; k = k + 1) begin
            j = k == 0 ? 3 : k == 2 ? 4 : 0;
            cntIn <= k == 0 ? 16'h0103 : k == 1 ? 16'h0100 : 16'(j);
            run(k < 2 ? `SCBM_OP_MOVE_B : `SCBM_OP_MOVE_W, 8 + 4 * j, 2'h3,
                32'h80 + j);
        end
        // The word move copied all four source bytes last.
        for (k = 0; k < 4; k = k + 1) begin
            keep = u_mem.mem[8'h40 + k];
            cmp("copy", keep, u_mem.mem[8'h80 + k]);
        end
        print_verdict;
    end
endmodule
